// ===== hw/chan_div_pkg.sv
// Constants shared by the cascaded channel clock divider
// =====================================================================
// What this block does
// - Stage 2.1 output stays low for low field [7:4] plus one cycles.
// - Stage 2.1 output stays high for high field [3:0] plus one cycles.
// - Stage 2.2 low and high times come from its own register, plus one.
// - The phase register resets to zero and reads back; no stage uses it.
// - Control bit 5 bypasses stage 2.2, passing its input straight through.
// - Control bit 4 bypasses stage 2.1, passing its input straight through.
// - Control bit 3 clear lets sync restart stages 2.1 and 2.2; set blocks only the restart.
// - Control bit 2 sets the static output level; software sets bit 3 first.
// - Control bits 1 and 0 pick the start levels of stages 2.2 and 2.1, high or low; stage 3.1 always starts low.
// - Correction register bit 0 set disables duty-cycle correction.
// - Stage 3.1 uses low [7:4] and high [3:0], each plus one cycles.
package chan_div_pkg;

    // =================================================================
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CH2_STAGE1 = 10'h199;
    localparam logic [9:0] IDX_CH2_PHASE = 10'h19a;
    localparam logic [9:0] IDX_CH2_STAGE2 = 10'h19b;
    localparam logic [9:0] IDX_CH2_CONTROL = 10'h19c;
    localparam logic [9:0] IDX_CH2_DCC = 10'h19d;
    localparam logic [9:0] IDX_CH3_STAGE1 = 10'h19e;
    localparam logic [9:0] IDX_STATUS = 10'h1a3;

    // =================================================================
    // Field positions
    localparam int LOW_MSB = 7;
    localparam int LOW_LSB = 4;
    localparam int HIGH_MSB = 3;
    localparam int HIGH_LSB = 0;
    localparam int CTL_BYPASS2 = 5;
    localparam int CTL_BYPASS1 = 4;
    localparam int CTL_NOSYNC = 3;
    localparam int CTL_FORCE = 2;
    localparam int CTL_START2 = 1;
    localparam int CTL_START1 = 0;
    localparam int DCC_DISABLE = 0;

    // =================================================================
    // Reset values
    localparam logic [7:0] RST_CYCLES = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_DCC = 8'h00;

    // AHB transfer type holding a real request
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// ===== hw/sub_divider.sv
// One programmable low/high sub-divider stage counting input ticks
module sub_divider
    import chan_div_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_tick,
    input wire logic in_level,
    input wire logic restart,
    input wire logic bypass,
    input wire logic start_high,
    input wire logic [3:0] low_cnt,
    input wire logic [3:0] high_cnt,
    output logic out_level,
    output logic out_tick
);

    logic level_reg;
    logic [3:0] cnt_reg;
    logic rise;

    // A tick is one input cycle; the output rises once per period
    assign rise = in_tick && !level_reg && (cnt_reg == low_cnt);

    // =================================================================
    // Phase counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_reg <= 1'b0;
            cnt_reg <= 4'h0;
        end
        else if (ce)
        begin
            if (restart || bypass)
            begin
                // Bypass parks the counter so it restarts cleanly
                level_reg <= start_high;
                cnt_reg <= 4'h0;
            end
            else if (in_tick)
            begin
                if (level_reg)
                begin
                    if (cnt_reg == high_cnt)
                    begin
                        level_reg <= 1'b0;
                        cnt_reg <= 4'h0;
                    end
                    else
                        cnt_reg <= cnt_reg + 4'h1;
                end
                else if (rise)
                begin
                    level_reg <= 1'b1;
                    cnt_reg <= 4'h0;
                end
                else
                    cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    assign out_level = bypass ? in_level : level_reg;
    assign out_tick = bypass ? in_tick : (rise && !restart);

    // =================================================================
    // Checks
    a_low_hold: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        (!bypass && !restart && in_tick && !level_reg
            && cnt_reg != low_cnt) |=> !level_reg)
        else $error("stage left low phase early");

    a_low_end: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        (!bypass && !restart && in_tick && !level_reg
            && cnt_reg == low_cnt) |=> level_reg && cnt_reg == 4'h0)
        else $error("stage did not rise after low count");

    a_high_end: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        (!bypass && !restart && in_tick && level_reg
            && cnt_reg == high_cnt) |=> !level_reg)
        else $error("stage did not fall after high count");

endmodule

// ===== hw/cascaded_channel_clock_divider.sv
// Cascaded channel clock divider with its AHB-Lite register slave
module cascaded_channel_clock_divider
    import chan_div_pkg::*;
#(
    parameter int PERIOD_W = 12
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sync_in,
    output logic ch2_clk_out,
    output logic ch3_stage1_clk_out
);

    logic [7:0] ch2_stage1_reg;
    logic [7:0] ch2_phase_reg;
    logic [7:0] ch2_stage2_reg;
    logic [7:0] ch2_control_reg;
    logic [7:0] ch2_dcc_reg;
    logic [7:0] ch3_stage1_reg;
    logic [31:0] hrdata_reg;
    logic wr_pend_reg;
    logic [9:0] wr_idx_reg;
    logic sync_meta_reg;
    logic sync_reg;
    logic ref_level_reg;
    logic ch2_out_reg;
    logic ch3_out_reg;
    logic [PERIOD_W-1:0] period_cnt_reg;
    logic [PERIOD_W-1:0] period_reg;
    logic addr_ok;
    logic [9:0] addr_idx;
    logic restart;
    logic s1_level;
    logic s1_tick;
    logic s2_level;
    logic s2_tick;
    logic s3_level;
    logic dcc_level;
    logic [PERIOD_W-1:0] half_period;
    logic [7:0] rd_value;
    logic [7:0] wr_byte;

    // Register index decoding, used only for reads; writes compare each index
    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == IDX_CH2_STAGE1) || (idx == IDX_CH2_PHASE)
            || (idx == IDX_CH2_STAGE2) || (idx == IDX_CH2_CONTROL)
            || (idx == IDX_CH2_DCC) || (idx == IDX_CH3_STAGE1)
            || (idx == IDX_STATUS);
    endfunction

    // =================================================================
    // AHB-Lite slave: zero wait states, always OKAY
    assign addr_idx = haddr[11:2];
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign wr_byte = hwdata[7:0];

    // Read value, forwarding a write still in its data phase
    always_comb
    begin
        rd_value = 8'h00;
        if (wr_pend_reg && wr_idx_reg == addr_idx
            && addr_idx != IDX_STATUS)
            rd_value = wr_byte;
        else if (addr_idx == IDX_CH2_STAGE1)
            rd_value = ch2_stage1_reg;
        else if (addr_idx == IDX_CH2_PHASE)
            rd_value = ch2_phase_reg;
        else if (addr_idx == IDX_CH2_STAGE2)
            rd_value = ch2_stage2_reg;
        else if (addr_idx == IDX_CH2_CONTROL)
            rd_value = {2'b00, ch2_control_reg[5:0]};
        else if (addr_idx == IDX_CH2_DCC)
            rd_value = {7'h00, ch2_dcc_reg[DCC_DISABLE]};
        else if (addr_idx == IDX_CH3_STAGE1)
            rd_value = ch3_stage1_reg;
        else if (addr_idx == IDX_STATUS)
            rd_value = {3'b000, ch3_out_reg, ch2_out_reg, s2_level,
                s1_level, sync_reg};
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 10'h000;
            hrdata_reg <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (hready)
            begin
                wr_pend_reg <= addr_ok && hwrite
                    && (haddr[31:12] == 20'h00000);
                wr_idx_reg <= addr_idx;
            end
            if (addr_ok && !hwrite)
            begin
                if (idx_mapped(addr_idx) && haddr[31:12] == 20'h00000)
                    hrdata_reg <= {24'h000000, rd_value};
                else
                    hrdata_reg <= 32'h0000_0000;
            end
        end
    end

    // =================================================================
    // Configuration registers, written in the data phase
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch2_stage1_reg <= RST_CYCLES;
            ch2_phase_reg <= RST_PHASE;
            ch2_stage2_reg <= RST_CYCLES;
            ch2_control_reg <= RST_CONTROL;
            ch2_dcc_reg <= RST_DCC;
            ch3_stage1_reg <= RST_CYCLES;
        end
        else if (ce && wr_pend_reg)
        begin
            if (wr_idx_reg == IDX_CH2_STAGE1)
                ch2_stage1_reg <= wr_byte;
            if (wr_idx_reg == IDX_CH2_PHASE)
                ch2_phase_reg <= wr_byte;
            if (wr_idx_reg == IDX_CH2_STAGE2)
                ch2_stage2_reg <= wr_byte;
            if (wr_idx_reg == IDX_CH2_CONTROL)
                ch2_control_reg <= {2'b00, wr_byte[5:0]};
            if (wr_idx_reg == IDX_CH2_DCC)
                ch2_dcc_reg <= {7'h00, wr_byte[DCC_DISABLE]};
            if (wr_idx_reg == IDX_CH3_STAGE1)
                ch3_stage1_reg <= wr_byte;
        end
    end

    // =================================================================
    // Sync pin synchroniser and reference level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else if (ce)
        begin
            sync_meta_reg <= sync_in;
            sync_reg <= sync_meta_reg;
        end
    end

    // Stands in for the raw input clock level when stage 2.1 is bypassed
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ref_level_reg <= 1'b0;
        else if (ce)
            ref_level_reg <= !ref_level_reg;
    end

    assign restart = sync_reg && !ch2_control_reg[CTL_NOSYNC];

    // =================================================================
    // Divider stages
    sub_divider u_stage21 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_tick(1'b1),
        .in_level(ref_level_reg),
        .restart(restart),
        .bypass(ch2_control_reg[CTL_BYPASS1]),
        .start_high(ch2_control_reg[CTL_START1]),
        .low_cnt(ch2_stage1_reg[LOW_MSB:LOW_LSB]),
        .high_cnt(ch2_stage1_reg[HIGH_MSB:HIGH_LSB]),
        .out_level(s1_level),
        .out_tick(s1_tick)
    );

    // Stage 2.2 counts whole periods of stage 2.1
    sub_divider u_stage22 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_tick(s1_tick),
        .in_level(s1_level),
        .restart(restart),
        .bypass(ch2_control_reg[CTL_BYPASS2]),
        .start_high(ch2_control_reg[CTL_START2]),
        .low_cnt(ch2_stage2_reg[LOW_MSB:LOW_LSB]),
        .high_cnt(ch2_stage2_reg[HIGH_MSB:HIGH_LSB]),
        .out_level(s2_level),
        .out_tick(s2_tick)
    );

    // Only the cycle fields of the next channel live here
    sub_divider u_stage31 (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_tick(1'b1),
        .in_level(ref_level_reg),
        .restart(1'b0),
        .bypass(1'b0),
        .start_high(1'b0),
        .low_cnt(ch3_stage1_reg[LOW_MSB:LOW_LSB]),
        .high_cnt(ch3_stage1_reg[HIGH_MSB:HIGH_LSB]),
        .out_level(s3_level),
        .out_tick()
    );

    // =================================================================
    // Duty-cycle correction: measure the period, stay high for half
    // Odd periods round the high half up; a limitation of a
    // single-edge design, traded for not needing the falling edge.
    assign half_period = (period_reg + PERIOD_W'(1)) >> 1;
    assign dcc_level = (period_cnt_reg < half_period);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            period_cnt_reg <= '0;
            period_reg <= '0;
        end
        else if (ce)
        begin
            if (s2_tick)
            begin
                period_reg <= period_cnt_reg + PERIOD_W'(1);
                period_cnt_reg <= '0;
            end
            else if (period_cnt_reg != '1)
                period_cnt_reg <= period_cnt_reg + PERIOD_W'(1);
        end
    end

    // =================================================================
    // Channel outputs
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch2_out_reg <= 1'b0;
            ch3_out_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (sync_reg)
                ch2_out_reg <= ch2_control_reg[CTL_FORCE];
            else if (ch2_dcc_reg[DCC_DISABLE] || period_reg < PERIOD_W'(2))
                ch2_out_reg <= s2_level;
            else
                ch2_out_reg <= dcc_level;
            ch3_out_reg <= s3_level;
        end
    end

    assign ch2_clk_out = ch2_out_reg;
    assign ch3_stage1_clk_out = ch3_out_reg;

    // =================================================================
    // Checks
    a_force_static_level: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        sync_reg |=> ch2_clk_out == $past(ch2_control_reg[CTL_FORCE]))
        else $error("forced level not shown during sync");

    a_nosync_ignore: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        ch2_control_reg[CTL_NOSYNC] |-> !restart)
        else $error("restart while sync ignored");

    a_sync_restart_level: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        (restart && !ch2_control_reg[CTL_BYPASS1]
            && $stable(ch2_control_reg))
            |=> s1_level == $past(ch2_control_reg[CTL_START1]))
        else $error("stage 2.1 did not restart at its start level");

    a_bypass1_pass: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        ch2_control_reg[CTL_BYPASS1] |-> s1_tick && s1_level == ref_level_reg)
        else $error("bypassed stage 2.1 not transparent");

    a_bypass2_pass: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        ch2_control_reg[CTL_BYPASS2] |-> s2_level == s1_level)
        else $error("bypassed stage 2.2 not transparent");

    a_cascade_tick: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        s2_tick |-> s1_tick)
        else $error("stage 2.2 advanced without stage 2.1 period");

    a_dcc_off_raw: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        (ch2_dcc_reg[DCC_DISABLE] && !sync_reg)
            |=> ch2_clk_out == $past(s2_level))
        else $error("raw stage output not passed with correction off");

    a_write_store: assert property (@(posedge sys_clk)
        disable iff (!rst_n || !ce)
        (wr_pend_reg && wr_idx_reg == IDX_CH2_STAGE1)
            |=> ch2_stage1_reg == $past(hwdata[7:0]))
        else $error("stage 2.1 cycle register not written");

endmodule

// ===== tb/cascaded_channel_clock_divider_bench.sv
// Self-checking bench for the cascaded channel clock divider
module cascaded_channel_clock_divider_bench
    import chan_div_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic rst_n;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sync_in;
    logic ch2_clk_out;
    logic ch3_stage1_clk_out;
    int bad_count;
    int total_checks;
    logic [31:0] rd;
    int hi;
    int lo;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    cascaded_channel_clock_divider #(
        .PERIOD_W(12)
    )
    u_dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .sync_in(sync_in),
        .ch2_clk_out(ch2_clk_out),
        .ch3_stage1_clk_out(ch3_stage1_clk_out)
    );

    // =================================================================
    // Clock, reset and watchdog
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(25 * 40000);
        bad_count++;
        tally_and_finish();
    end

    // =================================================================
    // Shared tasks
    function automatic logic [31:0] addr_of(input logic [9:0] idx);
        return {20'h00000, idx, 2'b00};
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge sys_clk);
        while (hready !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 100)
            check("bus ready", 32'h0, 32'h1);
    endtask

    task automatic bus_access(input logic wr, input logic [31:0] a,
                              input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        check("bus response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic bus_write(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus_access(1'b1, addr_of(idx), {24'h0, d}, q);
    endtask

    task automatic bus_read(input logic [9:0] idx, output logic [31:0] q);
        bus_access(1'b0, addr_of(idx), 32'h0, q);
    endtask

    // Length of one full high phase and the following low phase
    task automatic measure(input bit ch3, output int h, output int l);
        int n;
        n = 0;
        h = 0;
        l = 0;
        while ((ch3 ? ch3_stage1_clk_out : ch2_clk_out) !== 1'b0 && n < 9000)
        begin
            @(negedge sys_clk);
            n++;
        end
        while ((ch3 ? ch3_stage1_clk_out : ch2_clk_out) !== 1'b1 && n < 9000)
        begin
            @(negedge sys_clk);
            n++;
        end
        while ((ch3 ? ch3_stage1_clk_out : ch2_clk_out) === 1'b1 && n < 9000)
        begin
            @(negedge sys_clk);
            h++;
            n++;
        end
        while ((ch3 ? ch3_stage1_clk_out : ch2_clk_out) === 1'b0 && n < 9000)
        begin
            @(negedge sys_clk);
            l++;
            n++;
        end
    endtask

    task automatic pulse_sync(input int hold_cycles);
        sync_in <= 1'b1;
        repeat (hold_cycles) @(posedge sys_clk);
        sync_in <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // =================================================================
    // Tests
    initial
    begin
        logic [9:0] idx [6];
        logic [7:0] msk [6];
        bad_count = 0;
        total_checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        sync_in = 1'b0;
        idx = '{IDX_CH2_STAGE1, IDX_CH2_PHASE, IDX_CH2_STAGE2,
                IDX_CH2_CONTROL, IDX_CH2_DCC, IDX_CH3_STAGE1};
        msk = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h01, 8'hff};
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;

        // Reset values, then write and read back every configuration register
        for (int i = 0; i < 6; i++)
        begin
            bus_read(idx[i], rd);
            check("reset value", rd, 32'h0);
            bus_write(idx[i], 8'ha5);
            bus_read(idx[i], rd);
            check("readback", rd, {24'h0, 8'ha5 & msk[i]});
        end
        bus_access(1'b1, 32'h0000_0700, 32'h0000_00ff, rd);
        bus_access(1'b0, 32'h0000_0700, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        $display("test registers done");

        // Stage 3.1: low 3 cycles, high 2 cycles
        bus_write(IDX_CH3_STAGE1, 8'h21);
        measure(1'b1, hi, lo);
        check("ch3 high", hi, 32'd2);
        check("ch3 low", lo, 32'd3);
        // Just after a rise: freeze in the second high cycle
        @(posedge sys_clk);
        ce <= 1'b0;
        repeat (7) @(negedge sys_clk);
        check("frozen ch3", {31'h0, ch3_stage1_clk_out}, 32'h1);
        @(posedge sys_clk);
        ce <= 1'b1;
        $display("test stage 3.1 done");

        // Stage 2.1 alone: stage 2.2 bypassed, correction off
        bus_write(IDX_CH2_DCC, 8'h01);
        bus_write(IDX_CH2_CONTROL, 8'h20);
        bus_write(IDX_CH2_STAGE1, 8'h42);
        measure(1'b0, hi, lo);
        check("stage 2.1 high", hi, 32'd3);
        check("stage 2.1 low", lo, 32'd5);

        // Stage 2.2 alone: stage 2.1 bypassed ticks every cycle
        bus_write(IDX_CH2_CONTROL, 8'h10);
        bus_write(IDX_CH2_STAGE2, 8'h13);
        measure(1'b0, hi, lo);
        check("stage 2.2 high", hi, 32'd4);
        check("stage 2.2 low", lo, 32'd2);
        $display("test single stages done");

        // Cascade: ratios 3 and 3 multiply to 9
        bus_write(IDX_CH2_CONTROL, 8'h00);
        bus_write(IDX_CH2_STAGE1, 8'h10);
        bus_write(IDX_CH2_STAGE2, 8'h01);
        measure(1'b0, hi, lo);
        measure(1'b0, hi, lo);
        check("cascade period", hi + lo, 32'd9);
        check("cascade high", hi, 32'd6);
        // Correction on: high for half the period, rounded up
        bus_write(IDX_CH2_DCC, 8'h00);
        measure(1'b0, hi, lo);
        measure(1'b0, hi, lo);
        check("corrected high", hi, 32'd5);
        check("corrected low", lo, 32'd4);
        $display("test cascade done");

        // Sync restart picks the start level of stage 2.1
        bus_write(IDX_CH2_DCC, 8'h01);
        bus_write(IDX_CH2_STAGE1, 8'hff);
        bus_write(IDX_CH2_CONTROL, 8'h21);
        pulse_sync(5);
        repeat (6) @(negedge sys_clk);
        check("start high", {31'h0, ch2_clk_out}, 32'h1);
        bus_write(IDX_CH2_CONTROL, 8'h20);
        pulse_sync(5);
        repeat (6) @(negedge sys_clk);
        check("start low", {31'h0, ch2_clk_out}, 32'h0);
        $display("test start level done");

        // Forced level with sync ignored, set first
        bus_write(IDX_CH2_CONTROL, 8'h28);
        bus_write(IDX_CH2_CONTROL, 8'h2c);
        sync_in <= 1'b1;
        repeat (5) @(negedge sys_clk);
        check("forced high", {31'h0, ch2_clk_out}, 32'h1);
        bus_read(IDX_STATUS, rd);
        check("status sync and output", rd & 32'h09, 32'h09);
        bus_write(IDX_CH2_CONTROL, 8'h28);
        repeat (5) @(negedge sys_clk);
        check("forced low", {31'h0, ch2_clk_out}, 32'h0);
        @(posedge sys_clk);
        sync_in <= 1'b0;
        $display("test forced level done");

        tally_and_finish();
    end
endmodule
